// ---- host_bus_model.sv ----
// Host controller model for the serial control bus
`default_nettype none
module host_bus_model
(
	input  wire logic clk,
	output var  logic cs_n,
	output var  logic sclk,
	output var  logic cmd,
	input  wire logic reply
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		cmd = 1'b0;
	end
	// Msb first, eight clocks per sclk period, reply taken at end of high phase
	task automatic frame(input logic [23:0] w, input int n, output logic [7:0] r);
		@(posedge clk);
		cs_n <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = n - 1; i >= 0; i--)
		begin
			cmd <= w[i];
			sclk <= 1'b0;
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			repeat (4) @(posedge clk);
			r = {r[6:0], reply};
		end
		sclk <= 1'b0;
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		cmd <= ~cmd;
		repeat (4) @(posedge clk);
	endtask : frame
endmodule : host_bus_model
`default_nettype wire

// ---- modem_tx_defines.svh ----
// Register addresses, field positions, reset values and timing for the transmit USART
`ifndef MODEM_TX_DEFINES_SVH
`define MODEM_TX_DEFINES_SVH

`define ADDR_MODE          8'he2
`define ADDR_TX_NORMAL     8'he3
`define ADDR_TX_SHORT      8'he4
`define ADDR_STATUS        8'he5

`define MODE_RESET         16'h0000
`define MODE_FMT_LSB       0
`define MODE_LEN_LSB       2
`define MODE_PAR_EN        4
`define MODE_PAR_ODD       5
`define MODE_STOP2         6
`define MODE_SCR_EN        7
`define MODE_PSK           8
`define MODE_PAT_LSB       9
`define MODE_PWRSAVE       11

`define STAT_READY         0
`define STAT_UNDER         1

`define BUS_ADDR_BITS      5'd7
`define BUS_BYTE_END       5'd15
`define BUS_WORD_END       5'd23
`define BUS_CNT_MAX        5'd24

`define CLK_HZ             25000000
`define BIT_RATE_BPS       1200
`define BIT_CYCLES         (`CLK_HZ / `BIT_RATE_BPS)
`define SHORT_STOP_EIGHTHS 7
`define SCR_ONES_LIMIT     7'd64
`define SCR_TAP_A          14
`define SCR_TAP_B          17

`endif

// ---- modem_tx_pkg.sv ----
// Types shared by the transmit USART files
`default_nettype none
package modem_tx_pkg;
	typedef enum logic [1:0] {FMT_PATTERN, FMT_ASYNC, FMT_SYNC, FMT_SPARE} fmt_t;
	typedef enum logic [1:0] {PAT_ONES, PAT_ZEROS, PAT_ALT, PAT_SPARE} pattern_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
endpackage : modem_tx_pkg
`default_nettype wire

// ---- modem_tx_usart.sv ----
// Transmit USART with serial control bus slave and scrambler output stage
`default_nettype none
`include "modem_tx_defines.svh"
module modem_tx_usart
#(
	parameter int BIT_CYCLES = `BIT_CYCLES
)
(
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic bus_cs_n,
	input  wire logic bus_sclk,
	input  wire logic bus_cmd,
	output var  logic reply_o,
	output var  logic reply_oe_n,
	output var  logic fsk_bit,
	output var  logic psk_bit,
	output var  logic bit_stb,
	output var  logic standby
);
	localparam int SHORT_CYCLES = (BIT_CYCLES * `SHORT_STOP_EIGHTHS) / 8;

	// Pin synchronisers
	logic [1:0] cs_sync_q;
	logic [1:0] sclk_sync_q;
	logic [1:0] cmd_sync_q;
	logic       sclk_prev_q;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cs_sync_q   <= 2'b11;
			sclk_sync_q <= 2'b00;
			cmd_sync_q  <= 2'b00;
			sclk_prev_q <= 1'b0;
		end
		else
		begin
			cs_sync_q   <= {cs_sync_q[0], bus_cs_n};
			sclk_sync_q <= {sclk_sync_q[0], bus_sclk};
			cmd_sync_q  <= {cmd_sync_q[0], bus_cmd};
			sclk_prev_q <= sclk_sync_q[1];
		end
	end

	wire cs_act = !cs_sync_q[1];
	wire s_rise = cs_act && sclk_sync_q[1] && !sclk_prev_q;
	wire s_fall = cs_act && !sclk_sync_q[1] && sclk_prev_q;

	// Control bus slave
	logic [4:0]  bcnt_q;
	logic [15:0] bsh_q;
	logic [7:0]  addr_q;
	logic [7:0]  rsh_q;
	logic        rd_act_q;
	logic        reply_q;
	logic [15:0] mode_q;
	wire  [7:0]  rx_byte   = {bsh_q[6:0], cmd_sync_q[1]};
	wire         addr_done = s_rise && (bcnt_q == `BUS_ADDR_BITS);
	wire  [7:0]  addr_now  = addr_done ? rx_byte : addr_q;
	wire         is_tx     = (addr_q == `ADDR_TX_NORMAL) || (addr_q == `ADDR_TX_SHORT);
	wire         wr_tx     = s_rise && (bcnt_q == `BUS_BYTE_END) && is_tx;
	wire         wr_mode   = s_rise && (bcnt_q == `BUS_WORD_END) && (addr_q == `ADDR_MODE);
	wire         rd_stat   = addr_done && (addr_now == `ADDR_STATUS);

	// Mode fields
	wire                  pwr    = mode_q[`MODE_PWRSAVE];
	wire modem_tx_pkg::fmt_t     fmt = modem_tx_pkg::fmt_t'(mode_q[`MODE_FMT_LSB +: 2]);
	wire modem_tx_pkg::pattern_t pat = modem_tx_pkg::pattern_t'(mode_q[`MODE_PAT_LSB +: 2]);
	wire [1:0]            len    = mode_q[`MODE_LEN_LSB +: 2];
	wire                  psk    = mode_q[`MODE_PSK];
	wire                  is_sync  = (fmt == modem_tx_pkg::FMT_SYNC);
	wire                  is_async = (fmt == modem_tx_pkg::FMT_ASYNC);

	// Transmit state
	modem_tx_pkg::tx_state_t state_q;
	modem_tx_pkg::tx_state_t state_d;
	logic [14:0] tmr_q;
	logic [2:0]  idx_q;
	logic [2:0]  idx_d;
	logic [1:0]  stop_q;
	logic [1:0]  stop_d;
	logic [7:0]  buf_q;
	logic [7:0]  buf_d;
	logic        bshort_q;
	logic        bshort_d;
	logic        line_q;
	logic        line_d;
	logic        last_d;
	logic        take;
	logic        under_set;
	logic        sync_load;
	logic [7:0]  hold_q;
	logic        hold_full_q;
	logic        hold_short_q;
	logic        ready_q;
	logic        under_q;
	wire  [7:0]  status = {6'h00, under_q, ready_q};
	wire         bit_end = !pwr && (tmr_q == 15'h0000);
	wire  [7:0]  dmask  = 8'hff >> (2'd3 - len);
	wire         par    = (^(buf_q & dmask)) ^ mode_q[`MODE_PAR_ODD];
	wire  [2:0]  last_idx = is_sync ? 3'd7 : {1'b1, len};
	wire  [1:0]  nstop  = (mode_q[`MODE_STOP2] ? 2'd2 : 2'd1) - {1'b0, bshort_q && psk};

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bcnt_q   <= 5'h00;
			bsh_q    <= 16'h0000;
			addr_q   <= 8'h00;
			rsh_q    <= 8'h00;
			rd_act_q <= 1'b0;
			reply_q  <= 1'b0;
			mode_q   <= `MODE_RESET;
		end
		else if (!cs_act)
		begin
			bcnt_q   <= 5'h00;
			rd_act_q <= 1'b0;
		end
		else
		begin
			if (s_rise)
			begin
				bsh_q <= {bsh_q[14:0], cmd_sync_q[1]};
				if (bcnt_q != `BUS_CNT_MAX)
					bcnt_q <= bcnt_q + 5'h01;
			end
			if (addr_done)
				addr_q <= rx_byte;
			if (rd_stat)
			begin
				rsh_q    <= status;
				rd_act_q <= 1'b1;
			end
			else if (s_fall && rd_act_q)
			begin
				reply_q <= rsh_q[7];
				rsh_q   <= {rsh_q[6:0], 1'b0};
			end
			if (wr_mode)
				mode_q <= {bsh_q[14:0], cmd_sync_q[1]};
		end
	end

	// Next bit selection
	always_comb
	begin
		state_d   = state_q;
		idx_d     = idx_q;
		stop_d    = stop_q;
		buf_d     = buf_q;
		bshort_d  = bshort_q;
		line_d    = line_q;
		last_d    = 1'b0;
		take      = 1'b0;
		under_set = 1'b0;
		sync_load = 1'b0;
		if (bit_end)
		begin
			case (state_q)
				modem_tx_pkg::TX_IDLE:
				begin
					if (fmt == modem_tx_pkg::FMT_PATTERN)
						line_d = (pat == modem_tx_pkg::PAT_ZEROS) ? 1'b0 :
							((pat == modem_tx_pkg::PAT_ALT) ? !line_q : 1'b1);
					else if (is_sync)
						sync_load = 1'b1;
					else if (is_async && hold_full_q)
					begin
						take     = 1'b1;
						buf_d    = hold_q;
						bshort_d = hold_short_q;
						state_d  = modem_tx_pkg::TX_START;
						line_d   = 1'b0;
					end
					else
						line_d = 1'b1;
				end
				modem_tx_pkg::TX_START:
				begin
					state_d = modem_tx_pkg::TX_DATA;
					idx_d   = 3'd0;
					line_d  = buf_q[0];
				end
				modem_tx_pkg::TX_DATA:
				begin
					if (idx_q != last_idx)
					begin
						idx_d  = idx_q + 3'd1;
						line_d = buf_q[idx_q + 3'd1];
					end
					else if (is_sync)
						sync_load = 1'b1;
					else if (mode_q[`MODE_PAR_EN])
					begin
						state_d = modem_tx_pkg::TX_PARITY;
						line_d  = par;
					end
					else
						state_d = modem_tx_pkg::TX_PARITY;
				end
				modem_tx_pkg::TX_PARITY, modem_tx_pkg::TX_STOP:
					state_d = modem_tx_pkg::TX_STOP;
				default:
					state_d = modem_tx_pkg::TX_IDLE;
			endcase
			// Parity skipped or stop entry
			if ((state_q == modem_tx_pkg::TX_DATA && state_d == modem_tx_pkg::TX_PARITY
				&& !mode_q[`MODE_PAR_EN]) || state_q == modem_tx_pkg::TX_PARITY)
			begin
				stop_d  = nstop;
				state_d = modem_tx_pkg::TX_STOP;
			end
			else if (state_q == modem_tx_pkg::TX_STOP)
				stop_d = stop_q;
			if (state_d == modem_tx_pkg::TX_STOP)
			begin
				if (stop_d != 2'd0)
				begin
					stop_d = stop_d - 2'd1;
					line_d = 1'b1;
					last_d = bshort_q && !psk && (stop_d == 2'd0);
				end
				else if (hold_full_q)
				begin
					take     = 1'b1;
					buf_d    = hold_q;
					bshort_d = hold_short_q;
					state_d  = modem_tx_pkg::TX_START;
					line_d   = 1'b0;
				end
				else
				begin
					under_set = 1'b1;
					state_d   = modem_tx_pkg::TX_IDLE;
					line_d    = 1'b1;
				end
			end
			if (sync_load)
			begin
				state_d = modem_tx_pkg::TX_DATA;
				idx_d   = 3'd0;
				if (hold_full_q)
				begin
					take   = 1'b1;
					buf_d  = hold_q;
					line_d = hold_q[0];
				end
				else
				begin
					under_set = 1'b1;
					line_d    = buf_q[0];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q  <= modem_tx_pkg::TX_IDLE;
			tmr_q    <= 15'h0000;
			idx_q    <= 3'd0;
			stop_q   <= 2'd0;
			buf_q    <= 8'h00;
			bshort_q <= 1'b0;
			line_q   <= 1'b1;
		end
		else if (pwr)
		begin
			state_q <= modem_tx_pkg::TX_IDLE;
			tmr_q   <= 15'h0000;
			line_q  <= 1'b1;
		end
		else
		begin
			state_q  <= state_d;
			idx_q    <= idx_d;
			stop_q   <= stop_d;
			buf_q    <= buf_d;
			bshort_q <= bshort_d;
			line_q   <= line_d;
			if (bit_end)
				tmr_q <= last_d ? 15'(SHORT_CYCLES - 1) : 15'(BIT_CYCLES - 1);
			else
				tmr_q <= tmr_q - 15'h0001;
		end
	end

	// Holding register and status flags
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hold_q       <= 8'h00;
			hold_full_q  <= 1'b0;
			hold_short_q <= 1'b0;
			ready_q      <= 1'b1;
			under_q      <= 1'b0;
		end
		else
		begin
			if (wr_tx)
			begin
				hold_q       <= rx_byte;
				hold_short_q <= (addr_q == `ADDR_TX_SHORT) && is_async;
			end
			hold_full_q <= wr_tx || (hold_full_q && !take);
			ready_q     <= take || (ready_q && !wr_tx);
			under_q     <= under_set || (under_q && !rd_stat);
		end
	end

	// Scrambler and modulator routing
	logic scr_out;
	logic scr_vld;
	logic fsk_q;
	logic psk_q;
	logic stb_q;
	tx_scrambler u_scr
	(
		.clk    (clk),
		.arst_n (arst_n),
		.clr    (pwr),
		.en     (bit_end),
		.scr_en (mode_q[`MODE_SCR_EN]),
		.din    (line_d),
		.dout   (scr_out),
		.vld    (scr_vld)
	);
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fsk_q <= 1'b1;
			psk_q <= 1'b1;
			stb_q <= 1'b0;
		end
		else
		begin
			fsk_q <= psk ? 1'b1 : scr_out;
			psk_q <= psk ? scr_out : 1'b1;
			stb_q <= scr_vld;
		end
	end

	assign reply_o    = reply_q;
	assign reply_oe_n = !rd_act_q;
	assign fsk_bit    = fsk_q;
	assign psk_bit    = psk_q;
	assign bit_stb    = stb_q;
	assign standby    = pwr;

	AST_READY_SET: assert property (@(posedge clk) disable iff (!arst_n)
		take |=> ready_q) else $error("ready not set on transfer");
	AST_READY_CLR: assert property (@(posedge clk) disable iff (!arst_n)
		wr_tx && !take |=> !ready_q && hold_full_q) else $error("ready not cleared");
	AST_UNDER_SET: assert property (@(posedge clk) disable iff (!arst_n)
		bit_end && sync_load && !hold_full_q |=> under_q) else $error("underflow missed");
	AST_SYNC_RESEND: assert property (@(posedge clk) disable iff (!arst_n)
		sync_load && !hold_full_q |=> buf_q == $past(buf_q) && line_q == buf_q[0])
		else $error("sync resend wrong");
	AST_ASYNC_MARK: assert property (@(posedge clk) disable iff (!arst_n)
		under_set && is_async && !wr_tx |=> line_q && state_q == modem_tx_pkg::TX_IDLE)
		else $error("no mark after underflow");
	AST_START_LOW: assert property (@(posedge clk) disable iff (!arst_n)
		state_q == modem_tx_pkg::TX_START |-> !line_q) else $error("start bit high");
	AST_STOP_HIGH: assert property (@(posedge clk) disable iff (!arst_n)
		state_q == modem_tx_pkg::TX_STOP |-> line_q) else $error("stop bit low");
	AST_SHORT_STOP: assert property (@(posedge clk) disable iff (!arst_n)
		bit_end && last_d |=> tmr_q == 15'(SHORT_CYCLES - 1)) else $error("stop not short");
	AST_STANDBY: assert property (@(posedge clk) disable iff (!arst_n)
		pwr |=> state_q == modem_tx_pkg::TX_IDLE && tmr_q == 15'h0000 && line_q ##1 !stb_q)
		else $error("tx active in standby");
	COV_TAKE:  cover property (@(posedge clk) disable iff (!arst_n) take);
	COV_UNDER: cover property (@(posedge clk) disable iff (!arst_n) under_set && is_async);
	COV_SHORT: cover property (@(posedge clk) disable iff (!arst_n) bit_end && last_d);
	COV_READ:  cover property (@(posedge clk) disable iff (!arst_n) rd_stat);
endmodule : modem_tx_usart
`default_nettype wire

// ---- modem_tx_usart_scrambler_tb.sv ----
// Self-checking bench for the transmit USART with scrambler
`default_nettype none
`include "modem_tx_defines.svh"
module modem_tx_usart_scrambler_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BC = 40;
	typedef struct {logic b; int len;} note_t;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	wire         cs_n, sclk, cmd, reply_o, reply_oe_n, fsk_bit, psk_bit, bit_stb, standby;
	wire         reply_w = reply_oe_n ? 1'bz : reply_o;
	int          fails = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          since = 0;
	int          plen = 0;
	note_t       q[$];
	logic        idle = 1'b1;
	logic        psk = 1'b0;
	logic        in_fr = 1'b0;
	logic        lb;
	logic [31:0] seed = 32'h0000515b;
	logic [7:0]  r, a, b;
	logic [16:0] h;
	logic        o;

	modem_tx_usart #(.BIT_CYCLES(BC)) dut_u (.clk(clk), .arst_n(arst_n), .bus_cs_n(cs_n),
		.bus_sclk(sclk), .bus_cmd(cmd), .reply_o(reply_o), .reply_oe_n(reply_oe_n),
		.fsk_bit(fsk_bit), .psk_bit(psk_bit), .bit_stb(bit_stb), .standby(standby));
	host_bus_model host_u (.clk(clk), .cs_n(cs_n), .sclk(sclk), .cmd(cmd), .reply(reply_w));

	always #20 clk = ~clk;

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	task automatic tally(input logic ok, input string what);
		num_checks++;
		if (!ok)
		begin
			fails++;
			$display("Error at %0t: %s mismatch", $time, what);
		end
	endtask : tally
	task automatic check_bit(input logic got, input logic exp);
		tally(got === exp, "stream bit");
	endtask : check_bit
	task automatic check_len(input int got, input int exp);
		tally(got == exp, "bit length");
	endtask : check_len
	task automatic check_status(input logic [7:0] got, input logic [7:0] exp);
		tally(got === exp, "status");
	endtask : check_status

	task automatic final_report();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	task automatic mode(input logic [15:0] m);
		host_u.frame({`ADDR_MODE, m}, 24, r);
	endtask : mode
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		host_u.frame({8'h00, ad, d}, 16, r);
	endtask : wr
	task automatic status(input logic [7:0] e);
		host_u.frame({8'h00, `ADDR_STATUS, 8'h00}, 16, r);
		check_status(r, e);
	endtask : status
	task automatic push_bits(input logic [7:0] v, input int n);
		for (int i = 0; i < n; i++)
			q.push_back(note_t'{v[i], BC});
	endtask : push_bits
	// Start, data lsb first, optional parity, stops; optional shortened last stop
	task automatic push_char(input logic [7:0] d, input int len, input logic par,
		input logic odd, input int stops, input logic shrt);
		push_bits(8'h00, 1);
		push_bits(d, len);
		if (par)
			push_bits({7'h00, ^(d & (8'hff >> (8 - len))) ^ odd}, 1);
		push_bits(8'hff, stops);
		if (shrt)
			q[$].len = BC * 7 / 8;
	endtask : push_char
	task automatic drain();
		while (q.size() != 0)
			@(posedge clk);
	endtask : drain

	// Output watcher: skip idle level, then compare each bit with the oldest note
	always @(posedge clk)
	begin
		cyc++;
		since++;
		if (bit_stb === 1'b1)
		begin
			lb = psk ? psk_bit : fsk_bit;
			if (plen != 0)
				check_len(since, plen);
			plen = 0;
			if (q.size() != 0 && (in_fr || lb !== idle))
			begin
				check_bit(psk ? fsk_bit : psk_bit, 1'b1);
				check_bit(lb, q[0].b);
				plen = q[0].len;
				void'(q.pop_front());
				in_fr = q.size() != 0;
			end
			since = 0;
		end
		if (cyc == 30000)
		begin
			fails++;
			final_report();
		end
	end

	initial
	begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		status(8'h01);
		for (int l = 0; l < 4; l++)
		begin
			mode(16'h0031 | 16'(l << 2));
			a = rnd();
			push_char(a, l + 5, 1'b1, 1'b1, 1, 1'b0);
			wr(`ADDR_TX_NORMAL, a);
			drain();
		end
		status(8'h03);
		mode(16'h005d);
		a = rnd();
		b = rnd();
		push_char(a, 8, 1'b1, 1'b0, 2, 1'b0);
		push_char(b, 8, 1'b1, 1'b0, 2, 1'b0);
		push_bits(8'h03, 2);
		wr(`ADDR_TX_NORMAL, a);
		wr(`ADDR_TX_NORMAL, b);
		status(8'h00);
		drain();
		status(8'h03);
		status(8'h01);
		mode(16'h014d);
		psk = 1'b1;
		a = rnd();
		b = rnd();
		push_char(a, 8, 1'b0, 1'b0, 1, 1'b0);
		push_char(b, 8, 1'b0, 1'b0, 2, 1'b0);
		push_bits(8'h01, 1);
		wr(`ADDR_TX_SHORT, a);
		wr(`ADDR_TX_NORMAL, b);
		drain();
		mode(16'h000d);
		psk = 1'b0;
		a = rnd();
		push_char(a, 8, 1'b0, 1'b0, 1, 1'b1);
		push_bits(8'h01, 1);
		wr(`ADDR_TX_SHORT, a);
		drain();
		for (int k = 0; k < 3; k++)
		begin
			mode(k == 0 ? 16'h0000 : (k == 1 ? 16'h0300 : 16'h0400));
			psk = (k == 1);
			b = k == 0 ? 8'hff : (k == 1 ? 8'h00 : 8'haa);
			idle = ~b[0];
			repeat (2 * BC) @(posedge clk);
			push_bits(b, 6);
			drain();
		end
		mode(16'h0002);
		psk = 1'b0;
		idle = 1'b0;
		wr(`ADDR_TX_NORMAL, 8'h00);
		repeat (20 * BC) @(posedge clk);
		push_bits(8'ha5, 8);
		push_bits(8'ha5, 8);
		wr(`ADDR_TX_SHORT, 8'ha5);
		drain();
		status(8'h03);
		mode(16'h0880);
		check_bit(standby, 1'b1);
		mode(16'h0080);
		idle = 1'b1;
		h = 17'h00000;
		for (int i = 0; i < 70; i++)
		begin
			o = 1'b1 ^ (i == 64) ^ h[13] ^ h[16];
			h = {h[15:0], o};
			if (i >= 14)
				q.push_back(note_t'{o, BC});
		end
		drain();
		final_report();
	end
endmodule : modem_tx_usart_scrambler_tb
`default_nettype wire

// ---- tx_scrambler.sv ----
// Self-synchronising bit scrambler with long-ones breaker
`default_nettype none
`include "modem_tx_defines.svh"
module tx_scrambler
(
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic clr,
	input  wire logic en,
	input  wire logic scr_en,
	input  wire logic din,
	output var  logic dout,
	output var  logic vld
);
	logic [16:0] sr_q;
	logic [6:0]  ones_q;
	logic        dout_q;
	logic        vld_q;
	wire         inv  = scr_en && (ones_q == `SCR_ONES_LIMIT);
	wire         dinx = din ^ inv;
	wire         sout = dinx ^ sr_q[`SCR_TAP_A-1] ^ sr_q[`SCR_TAP_B-1];
	wire  [6:0]  ones_d = (inv || !din) ? 7'h00 :
		((ones_q == `SCR_ONES_LIMIT) ? ones_q : ones_q + 7'h01);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sr_q   <= 17'h00000;
			ones_q <= 7'h00;
			dout_q <= 1'b1;
			vld_q  <= 1'b0;
		end
		else if (clr)
		begin
			sr_q   <= 17'h00000;
			ones_q <= 7'h00;
			dout_q <= 1'b1;
			vld_q  <= 1'b0;
		end
		else
		begin
			vld_q <= en;
			if (en)
			begin
				ones_q <= ones_d;
				dout_q <= scr_en ? sout : din;
				if (scr_en)
					sr_q <= {sr_q[15:0], sout};
			end
		end
	end

	assign dout = dout_q;
	assign vld  = vld_q;

	AST_SCR_POLY: assert property (@(posedge clk) disable iff (!arst_n)
		en && scr_en && !clr |=> dout == ($past(din) ^ $past(inv)
			^ $past(sr_q[`SCR_TAP_A-1]) ^ $past(sr_q[`SCR_TAP_B-1])))
		else $error("scrambler output mismatch");
	AST_SCR_BREAK: assert property (@(posedge clk) disable iff (!arst_n)
		scr_en && ones_q == `SCR_ONES_LIMIT && en && !clr |=> ones_q == 7'h00)
		else $error("ones run not broken");
endmodule : tx_scrambler
`default_nettype wire
